// File: design/lgc_pkg.sv
// Constants for the luminance and gamma control block
package lgc_pkg;
  localparam int          REG_AW = 8;
  localparam logic [7:0]  ADR_ROW_BLANK_HI   = 8'h07;
  localparam logic [7:0]  ADR_ROW_BLANK_LO   = 8'h08;
  localparam logic [7:0]  ADR_LOOP_TUNING    = 8'h0F;
  localparam logic [7:0]  ADR_PEAK_CURRENT   = 8'h12;
  localparam logic [7:0]  ADR_BRIGHT_STEP    = 8'h13;
  localparam logic [7:0]  ADR_AUX_CFG0       = 8'h34;
  localparam logic [7:0]  ADR_AUX_CFG1       = 8'h35;
  localparam logic [7:0]  ADR_LOOP_SELECT    = 8'h40;
  localparam logic [7:0]  ADR_PROBE_CONFIG   = 8'h41;
  localparam logic [7:0]  ADR_STATUS         = 8'h42;
  localparam logic [7:0]  RST_ROW_BLANK_HI   = 8'h00;
  localparam logic [7:0]  RST_ROW_BLANK_LO   = 8'h00;
  localparam logic [7:0]  RST_LOOP_TUNING    = 8'h3D;
  localparam logic [7:0]  RST_PEAK_CURRENT   = 8'h00;
  localparam logic [6:0]  RST_BRIGHT_STEP    = 7'h7F;
  localparam logic [7:0]  RST_AUX_CFG        = 8'h99;
  localparam logic [3:0]  RST_LOOP_SELECT    = 4'h0;
  localparam logic [2:0]  RST_GRAY_SELECT    = 3'h0;
  localparam logic [7:0]  READ_UNMAPPED      = 8'h00;
  localparam int          BRIGHT_W           = 7;
  localparam logic [6:0]  BRIGHT_FULL        = 7'h7F;
  localparam int          ROW_BLANK_W        = 10;
  localparam int          ROW_BLANK_HI_W     = 2;
  localparam int          LOOP_SEL_W         = 4;
  localparam int          GRAY_SEL_W         = 3;
  localparam int          PEAK_COARSE_LSB    = 3;
  localparam int          PEAK_COARSE_W      = 5;
  localparam int          PEAK_FINE_W        = 3;
  localparam logic [3:0]  LOOP_AUTO          = 4'h0;
  localparam logic [3:0]  LOOP_HYBRID        = 4'h1;
  localparam logic [3:0]  LOOP_MANUAL        = 4'h2;
  localparam logic [5:0]  DEV_ADDR_BASE      = 6'h13;
  localparam int          LINE_CNT_W         = 12;
  localparam int          STAT_DIM_BIT       = 0;
  localparam int          STAT_PROBE_BIT     = 1;
  localparam int          STAT_BLANK_BIT     = 2;
  localparam int          STAT_W             = 3;
  localparam logic [3:0]  BIT_ACK            = 4'h8;
  localparam logic [3:0]  BIT_ACK_END        = 4'h9;

  typedef enum logic [4:0] {
    LGC_IDLE = 5'b00001,
    LGC_DEV  = 5'b00010,
    LGC_REG  = 5'b00100,
    LGC_WR   = 5'b01000,
    LGC_RD   = 5'b10000
  } lgc_link_state_e;
endpackage

// File: design/lgc_serial_slave.sv
// Two-wire serial register slave, running on the link clock
`timescale 1ns/100ps
`default_nettype none
module lgc_serial_slave
  import lgc_pkg::*;
(
  input  wire logic              link_clk,
  input  wire logic              link_rst_n,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  input  wire logic              addr_sel,
  output logic                   sda_oe,
  output logic [lgc_pkg::REG_AW-1:0] reg_addr,
  output logic                   wr_en,
  output logic [7:0]             wr_data,
  input  wire logic [7:0]        rd_data
);
  lgc_link_state_e state;
  logic [1:0] scl_sy;
  logic [1:0] sda_sy;
  logic [1:0] sel_sy;
  logic       scl_p;
  logic       sda_p;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;

  // Pins are sampled twice before any decode reads them
  wire scl_s    = scl_sy[1];
  wire sda_s    = sda_sy[1];
  wire start_ev = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_ev  = scl_s & scl_p & ~sda_p & sda_s;
  wire rise     = scl_s & ~scl_p;
  wire fall     = ~scl_s & scl_p;
  wire addr_hit = shift[7:1] == {DEV_ADDR_BASE, sel_sy[1]};
  assign wr_data = shift;

  always_ff @(posedge link_clk)
  begin
    scl_sy <= {scl_sy[0], scl_in};
    sda_sy <= {sda_sy[0], sda_in};
    sel_sy <= {sel_sy[0], addr_sel};
    scl_p  <= scl_s;
    sda_p  <= sda_s;
  end

  always_ff @(posedge link_clk)
  begin
    wr_en <= 1'b0;
    if (!link_rst_n)
    begin
      state    <= LGC_IDLE;
      bit_cnt  <= '0;
      shift    <= '0;
      tx       <= '0;
      sda_oe   <= 1'b0;
      reg_addr <= '0;
    end
    else if (start_ev)
    begin
      state   <= LGC_DEV;
      bit_cnt <= '0;
      sda_oe  <= 1'b0;
    end
    else if (stop_ev)
    begin
      state  <= LGC_IDLE;
      sda_oe <= 1'b0;
    end
    else if (rise && !state[0])
    begin
      // The ninth bit is taken too: in a read it is the master's ack
      shift <= {shift[6:0], sda_s};
      if (bit_cnt != BIT_ACK_END)
        bit_cnt <= bit_cnt + 4'h1;
    end
    else if (fall && !state[0])
    begin
      if (bit_cnt == BIT_ACK)
      begin
        bit_cnt <= BIT_ACK_END;
        unique case (state)
          LGC_DEV:
          begin
            sda_oe <= addr_hit;
            if (!addr_hit)
              state <= LGC_IDLE;
            else if (shift[0])
              state <= LGC_RD;
            else
              state <= LGC_REG;
          end
          LGC_REG:
          begin
            reg_addr <= shift;
            sda_oe   <= 1'b1;
            state    <= LGC_WR;
          end
          LGC_WR:
          begin
            wr_en  <= 1'b1;
            sda_oe <= 1'b1;
          end
          default:
            sda_oe <= 1'b0;
        endcase
      end
      else if (bit_cnt == BIT_ACK_END)
      begin
        bit_cnt <= '0;
        sda_oe  <= 1'b0;
        // A read goes on only while the ninth bit was pulled low
        if (state == LGC_RD && !shift[0])
        begin
          tx       <= rd_data;
          sda_oe   <= ~rd_data[7];
          reg_addr <= reg_addr + 8'h01;
        end
        else if (state == LGC_RD)
          state <= LGC_IDLE;
        else if (state == LGC_WR && wr_en)
          reg_addr <= reg_addr;
      end
      else if (state == LGC_RD && bit_cnt != 4'h0)
      begin
        tx     <= {tx[6:0], 1'b0};
        sda_oe <= ~tx[6];
      end
    end
    if (wr_en)
      reg_addr <= reg_addr + 8'h01;
  end
endmodule // lgc_serial_slave
`default_nettype wire

// File: design/lgc_top.sv
// Luminance, row blanking and gamma probe control with its register file
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Brightness step is 7 bits, 128 linear steps up to the peak level.
// - Brightness step dims only while cathode loop select is 0 or 1.
// - Peak current reference splits into a coarse and a fine field.
// - One of 8 gray points is selected; the probe shows its voltage.
// - Gamma probe works only while cathode loop select is 00h.
// - Count W blanks rows for the final 2W lines; zero disables.
// - Loop select 0 auto, 1 hybrid, 2 manual; manual disables dimming.
module lgc_top
  import lgc_pkg::*;
#(
  parameter int LINE_W = lgc_pkg::LINE_CNT_W
)
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   link_clk,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  input  wire logic                   serial_addr_sel,
  input  wire logic                   hsync_in,
  input  wire logic                   vsync_in,
  output logic [lgc_pkg::BRIGHT_W-1:0] brightness_level,
  output logic                        lum_reg_enable,
  output logic [lgc_pkg::PEAK_COARSE_W-1:0] peak_current_coarse,
  output logic [lgc_pkg::PEAK_FINE_W-1:0]   peak_current_fine,
  output logic [lgc_pkg::LOOP_SEL_W-1:0]    cathode_loop_select,
  output logic [7:0]                  cathode_loop_tuning,
  output logic [7:0]                  aux_tuning_config_0,
  output logic [7:0]                  aux_tuning_config_1,
  output logic                        probe_enable,
  output logic [lgc_pkg::GRAY_SEL_W-1:0]    gray_point_select,
  output logic                        row_black
);
  localparam int CFG_W = 56;

  // Link-domain register file
  logic [1:0]         link_rst_sy;
  wire                link_rst_n = link_rst_sy[1];
  logic [7:0]         reg_addr;
  logic               wr_en;
  logic [7:0]         wr_data;
  logic [7:0]         rd_data;
  logic [7:0]         r_row_hi;
  logic [7:0]         r_row_lo;
  logic [7:0]         r_tuning;
  logic [7:0]         r_peak;
  logic [6:0]         r_bright;
  logic [7:0]         r_aux0;
  logic [7:0]         r_aux1;
  logic [3:0]         r_loop;
  logic [2:0]         r_gray;
  logic [STAT_W-1:0]  stat_sy0;
  logic [STAT_W-1:0]  stat_sy1;
  logic               pend;
  logic               req_tg;
  logic [1:0]         ack_sy;
  logic [CFG_W-1:0]   hold;

  // System-domain copies
  logic [2:0]         req_sy;
  logic               ack_tg;
  logic [CFG_W-1:0]   cfg;
  logic [1:0]         hs_sy;
  logic [1:0]         vs_sy;
  logic               hs_p;
  logic               vs_p;
  logic [LINE_W-1:0]  line_cnt;
  logic [LINE_W-1:0]  frame_lines;
  logic [STAT_W-1:0]  stat_sys;

  assign sda_out = 1'b0;

  lgc_serial_slave u_slave (
    .link_clk   (link_clk),
    .link_rst_n (link_rst_n),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .addr_sel   (serial_addr_sel),
    .sda_oe     (sda_oe),
    .reg_addr   (reg_addr),
    .wr_en      (wr_en),
    .wr_data    (wr_data),
    .rd_data    (rd_data)
  );

  // Reset reaches the link side through two flops of its own clock
  always_ff @(posedge link_clk)
  begin
    link_rst_sy <= {link_rst_sy[0], rst_n};
  end

  wire wr_row_hi = wr_en && reg_addr == ADR_ROW_BLANK_HI;
  wire wr_row_lo = wr_en && reg_addr == ADR_ROW_BLANK_LO;
  wire wr_tuning = wr_en && reg_addr == ADR_LOOP_TUNING;
  wire wr_peak   = wr_en && reg_addr == ADR_PEAK_CURRENT;
  wire wr_bright = wr_en && reg_addr == ADR_BRIGHT_STEP;
  wire wr_aux0   = wr_en && reg_addr == ADR_AUX_CFG0;
  wire wr_aux1   = wr_en && reg_addr == ADR_AUX_CFG1;
  wire wr_loop   = wr_en && reg_addr == ADR_LOOP_SELECT;
  wire wr_probe  = wr_en && reg_addr == ADR_PROBE_CONFIG;

  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      r_row_hi <= RST_ROW_BLANK_HI;
      r_row_lo <= RST_ROW_BLANK_LO;
      r_tuning <= RST_LOOP_TUNING;
      r_peak   <= RST_PEAK_CURRENT;
      r_bright <= RST_BRIGHT_STEP;
      r_aux0   <= RST_AUX_CFG;
      r_aux1   <= RST_AUX_CFG;
      r_loop   <= RST_LOOP_SELECT;
      r_gray   <= RST_GRAY_SELECT;
    end
    else
    begin
      if (wr_row_hi)
        r_row_hi <= {6'h00, wr_data[ROW_BLANK_HI_W-1:0]};
      if (wr_row_lo)
        r_row_lo <= wr_data;
      if (wr_tuning)
        r_tuning <= wr_data;
      if (wr_peak)
        r_peak <= wr_data;
      if (wr_bright)
        r_bright <= wr_data[BRIGHT_W-1:0];
      if (wr_aux0)
        r_aux0 <= wr_data;
      if (wr_aux1)
        r_aux1 <= wr_data;
      if (wr_loop)
        r_loop <= wr_data[LOOP_SEL_W-1:0];
      if (wr_probe)
        r_gray <= wr_data[GRAY_SEL_W-1:0];
    end
  end

  // Status from the system side, level-synchronised
  always_ff @(posedge link_clk)
  begin
    stat_sy0 <= stat_sys;
    stat_sy1 <= stat_sy0;
  end

  always_comb
  begin
    unique case (reg_addr)
      ADR_ROW_BLANK_HI: rd_data = r_row_hi;
      ADR_ROW_BLANK_LO: rd_data = r_row_lo;
      ADR_LOOP_TUNING:  rd_data = r_tuning;
      ADR_PEAK_CURRENT: rd_data = r_peak;
      ADR_BRIGHT_STEP:  rd_data = {1'b0, r_bright};
      ADR_AUX_CFG0:     rd_data = r_aux0;
      ADR_AUX_CFG1:     rd_data = r_aux1;
      ADR_LOOP_SELECT:  rd_data = {4'h0, r_loop};
      ADR_PROBE_CONFIG: rd_data = {5'h00, r_gray};
      ADR_STATUS:       rd_data = {5'h00, stat_sy1};
      default:          rd_data = READ_UNMAPPED;
    endcase
  end

  // Whole configuration crosses as one word under a toggle handshake,
  // so the system side never sees half of a register update
  wire busy = req_tg != ack_sy[1];
  wire [CFG_W-1:0] cfg_now = {r_row_hi[1:0], r_row_lo, r_tuning, r_peak,
                              r_bright, r_aux0, r_aux1, r_loop, r_gray};

  always_ff @(posedge link_clk)
  begin
    ack_sy <= {ack_sy[0], ack_tg};
    if (!link_rst_n)
    begin
      pend   <= 1'b0;
      req_tg <= 1'b0;
      hold   <= '0;
    end
    else if (!busy && (pend || wr_en))
    begin
      // A write landing now is picked up on the next pass
      pend   <= wr_en;
      hold   <= cfg_now;
      req_tg <= ~req_tg;
    end
    else if (wr_en)
      pend <= 1'b1;
  end

  wire req_edge = req_sy[2] ^ req_sy[1];

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      req_sy <= '0;
      ack_tg <= 1'b0;
      cfg    <= {RST_ROW_BLANK_HI[1:0], RST_ROW_BLANK_LO, RST_LOOP_TUNING,
                 RST_PEAK_CURRENT, RST_BRIGHT_STEP, RST_AUX_CFG,
                 RST_AUX_CFG, RST_LOOP_SELECT, RST_GRAY_SELECT};
    end
    else
    begin
      req_sy <= {req_sy[1:0], req_tg};
      if (req_edge)
      begin
        cfg    <= hold;
        ack_tg <= ~ack_tg;
      end
    end
  end

  // Unpack the system-side copy
  wire [ROW_BLANK_W-1:0] row_count   = cfg[55:46];
  wire [7:0]             cfg_tuning  = cfg[45:38];
  wire [7:0]             cfg_peak    = cfg[37:30];
  wire [6:0]             cfg_bright  = cfg[29:23];
  wire [7:0]             cfg_aux0    = cfg[22:15];
  wire [7:0]             cfg_aux1    = cfg[14:7];
  wire [3:0]             cfg_loop    = cfg[6:3];
  wire [2:0]             cfg_gray    = cfg[2:0];

  wire loop_auto   = cfg_loop == LOOP_AUTO;
  wire loop_dimmed = loop_auto || cfg_loop == LOOP_HYBRID;
  wire dim_enable  = loop_dimmed;

  // Frame timing: line count of the last frame sets where blanking starts
  wire hs_rise = hs_sy[1] & ~hs_p;
  wire vs_rise = vs_sy[1] & ~vs_p;
  wire [LINE_W:0] blank_span = {{(LINE_W - ROW_BLANK_W){1'b0}},
                                row_count, 1'b0};
  wire [LINE_W:0] blank_start = {1'b0, frame_lines} - blank_span;
  wire blank_now = row_count != '0 && !blank_start[LINE_W] &&
                   line_cnt >= blank_start[LINE_W-1:0];

  always_ff @(posedge sys_clk)
  begin
    hs_sy <= {hs_sy[0], hsync_in};
    vs_sy <= {vs_sy[0], vsync_in};
    hs_p  <= hs_sy[1];
    vs_p  <= vs_sy[1];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      line_cnt    <= '0;
      frame_lines <= '0;
    end
    else if (vs_rise)
    begin
      frame_lines <= line_cnt;
      line_cnt    <= '0;
    end
    else if (hs_rise && line_cnt != '1)
      line_cnt <= line_cnt + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      brightness_level    <= BRIGHT_FULL;
      lum_reg_enable      <= 1'b1;
      peak_current_coarse <= RST_PEAK_CURRENT[7:PEAK_COARSE_LSB];
      peak_current_fine   <= RST_PEAK_CURRENT[PEAK_COARSE_LSB-1:0];
      cathode_loop_select <= RST_LOOP_SELECT;
      cathode_loop_tuning <= RST_LOOP_TUNING;
      aux_tuning_config_0 <= RST_AUX_CFG;
      aux_tuning_config_1 <= RST_AUX_CFG;
      probe_enable        <= 1'b1;
      gray_point_select   <= RST_GRAY_SELECT;
      row_black           <= 1'b0;
      stat_sys            <= '0;
    end
    else
    begin
      // Outside the dimming loops the step is parked at full scale
      brightness_level    <= dim_enable ? cfg_bright : BRIGHT_FULL;
      lum_reg_enable      <= loop_dimmed;
      peak_current_coarse <= cfg_peak[7:PEAK_COARSE_LSB];
      peak_current_fine   <= cfg_peak[PEAK_COARSE_LSB-1:0];
      cathode_loop_select <= cfg_loop;
      cathode_loop_tuning <= cfg_tuning;
      aux_tuning_config_0 <= cfg_aux0;
      aux_tuning_config_1 <= cfg_aux1;
      probe_enable        <= loop_auto;
      gray_point_select   <= cfg_gray;
      row_black           <= blank_now;
      stat_sys[STAT_DIM_BIT]   <= dim_enable;
      stat_sys[STAT_PROBE_BIT] <= loop_auto;
      stat_sys[STAT_BLANK_BIT] <= blank_now;
    end
  end
endmodule // lgc_top
`default_nettype wire

// File: verif/lgc_checker.sv
// Port assertions for the luminance and gamma control block
`timescale 1ns/100ps
`default_nettype none
module lgc_checker
  import lgc_pkg::*;
(
  input wire logic                           sys_clk,
  input wire logic                           rst_n,
  input wire logic                           sda_out,
  input wire logic [lgc_pkg::BRIGHT_W-1:0]   brightness_level,
  input wire logic                           lum_reg_enable,
  input wire logic [lgc_pkg::PEAK_COARSE_W-1:0] peak_current_coarse,
  input wire logic [lgc_pkg::LOOP_SEL_W-1:0] cathode_loop_select,
  input wire logic [7:0]                     cathode_loop_tuning,
  input wire logic [7:0]                     aux_tuning_config_0,
  input wire logic [7:0]                     aux_tuning_config_1,
  input wire logic                           probe_enable,
  input wire logic [lgc_pkg::GRAY_SEL_W-1:0] gray_point_select,
  input wire logic                           row_black
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_parked;
    !lum_reg_enable && brightness_level == BRIGHT_FULL;
  endsequence
  sequence s_defaults;
    brightness_level == RST_BRIGHT_STEP && lum_reg_enable && probe_enable
      && peak_current_coarse == 5'h00 && gray_point_select == 3'h0
      && cathode_loop_tuning == RST_LOOP_TUNING && !row_black
      && aux_tuning_config_0 == RST_AUX_CFG
      && aux_tuning_config_1 == RST_AUX_CFG;
  endsequence
  a_loop_enable_map: assert property (
    lum_reg_enable == (cathode_loop_select <= LOOP_HYBRID))
    else $error("dimming enable wrong for loop select");
  a_parked_bright: assert property (
    !lum_reg_enable |-> brightness_level == BRIGHT_FULL)
    else $error("brightness not parked outside loops 0 and 1");
  a_manual_mode_off: assert property (
    cathode_loop_select == LOOP_MANUAL |-> s_parked ##0 !probe_enable)
    else $error("manual loop left dimming or probe active");
  a_probe_auto_only: assert property (
    probe_enable == (cathode_loop_select == LOOP_AUTO))
    else $error("probe enable wrong for loop select");
  a_switch_together: assert property (
    $changed(lum_reg_enable) || $changed(probe_enable)
      |-> $changed(cathode_loop_select))
    else $error("mode outputs moved without loop select");
  a_reset_defaults: assert property (
    $rose(rst_n) |-> s_defaults)
    else $error("outputs not at defaults after reset");
  // First frame has no line total yet, so nothing may be blanked in the 8 cycles after reset
  a_black_first_frame: assert property (
    $rose(rst_n) |-> !row_black [*8])
    else $error("rows blanked right after reset");
  a_sda_open_drain: assert property (
    sda_out == 1'b0)
    else $error("data pin driven high");
endmodule // lgc_checker

bind lgc_top lgc_checker u_chk
(
  .sys_clk(sys_clk), .rst_n(rst_n), .sda_out(sda_out),
  .brightness_level(brightness_level), .lum_reg_enable(lum_reg_enable),
  .peak_current_coarse(peak_current_coarse),
  .cathode_loop_select(cathode_loop_select),
  .cathode_loop_tuning(cathode_loop_tuning),
  .aux_tuning_config_0(aux_tuning_config_0),
  .aux_tuning_config_1(aux_tuning_config_1),
  .probe_enable(probe_enable), .gray_point_select(gray_point_select),
  .row_black(row_black)
);
`default_nettype wire

// File: verif/lgc_host_model.sv
// Host controller model mastering the two-wire register port
`timescale 1ns/100ps
`default_nettype none
module lgc_host_model
#(
  parameter int HALF = 8
)
(
  input  wire logic link_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  logic [6:0] dev;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    dev = 7'h26;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask
  // Data moves only well after scl falls, past the slave's sync delay
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    tick(4);
    sda_low = ~b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    s = sda_line;
  endtask
  // Data falls under a high clock for a start and rises for a stop;
  // after a start the line stays low until the first bit takes over
  task automatic cond(input logic is_stop);
    scl = 1'b0;
    tick(4);
    sda_low = is_stop;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = ~is_stop;
    tick(HALF);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      output logic nak);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(1'b1, nak);
  endtask
  task automatic wr(input logic [7:0] ra, input int n, input logic [7:0] d0,
                    input logic [7:0] d1, output logic ok);
    logic [7:0] rx;
    logic [3:0] nk;
    nk = 4'h0;
    cond(1'b0);
    xfer({dev, 1'b0}, rx, nk[0]);
    xfer(ra, rx, nk[1]);
    xfer(d0, rx, nk[2]);
    if (n > 1)
      xfer(d1, rx, nk[3]);
    cond(1'b1);
    ok = (nk == 4'h0);
  endtask
  task automatic rd(input logic [7:0] ra, output logic [7:0] d,
                    output logic ok);
    logic [7:0] rx;
    logic [3:0] nk;
    cond(1'b0);
    xfer({dev, 1'b0}, rx, nk[0]);
    xfer(ra, rx, nk[1]);
    cond(1'b0);
    xfer({dev, 1'b1}, rx, nk[2]);
    xfer(8'hFF, d, nk[3]);
    cond(1'b1);
    ok = (nk[2:0] == 3'h0);
  endtask
  // Luminance from calibration bytes; slope is fixed point in 1/256
  function automatic int lum_nits(input logic [7:0] s_int, s_frac, o_lo,
                                  o_hi, code);
    int org;
    org = int'({o_hi, o_lo});
    if (code > 8'h20)
      lum_nits = (({s_int, s_frac} * code) >> 8) - org;
    else
      lum_nits = -1;
  endfunction
  function automatic int gamma_coef(input int probe_mv, supply_mv, cf_milli);
    int code;
    code = probe_mv * 32'h3FF / (supply_mv >> 1);
    gamma_coef = code * cf_milli / 32'h3E8;
  endfunction
endmodule // lgc_host_model
`default_nettype wire

// File: verif/lgc_top_tb.sv
// Self-checking bench for the luminance and gamma control block
`timescale 1ns/100ps
`default_nettype none
module lgc_top_tb;
  import lgc_pkg::*;
  logic                      sys_clk  = 1'b1;
  logic                      link_clk = 1'b0;
  logic                      rst_n    = 1'b0;
  logic                      addr_sel = 1'b0;
  logic                      hsync_in = 1'b0;
  logic                      vsync_in = 1'b0;
  wire logic                 scl;
  wire logic                 host_low;
  wire logic                 sda_line;
  logic                      sda_out;
  logic                      sda_oe;
  logic                      lum_reg_enable;
  logic                      probe_enable;
  logic                      row_black;
  logic [BRIGHT_W-1:0]       brightness_level;
  logic [PEAK_COARSE_W-1:0]  peak_current_coarse;
  logic [PEAK_FINE_W-1:0]    peak_current_fine;
  logic [LOOP_SEL_W-1:0]     cathode_loop_select;
  logic [7:0]                cathode_loop_tuning;
  logic [7:0]                aux_tuning_config_0;
  logic [7:0]                aux_tuning_config_1;
  logic [GRAY_SEL_W-1:0]     gray_point_select;
  int                        n_fail = 0;
  int                        checks_done = 0;
  int                        cycles = 0;
  int                        vcyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  always #7.5 link_clk = ~link_clk;
  // Open-drain data line with pull-up
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~host_low;
  lgc_host_model u_host
  (
    .link_clk(link_clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low)
  );
  lgc_top dut
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .serial_addr_sel(addr_sel), .hsync_in(hsync_in), .vsync_in(vsync_in),
    .brightness_level(brightness_level), .lum_reg_enable(lum_reg_enable),
    .peak_current_coarse(peak_current_coarse),
    .peak_current_fine(peak_current_fine),
    .cathode_loop_select(cathode_loop_select),
    .cathode_loop_tuning(cathode_loop_tuning),
    .aux_tuning_config_0(aux_tuning_config_0),
    .aux_tuning_config_1(aux_tuning_config_1),
    .probe_enable(probe_enable), .gray_point_select(gray_point_select),
    .row_black(row_black)
  );
  // Frames of 20 lines of 20 cycles; vsync rises mid-line to avoid ties
  always @(posedge sys_clk)
  begin
    #1;
    vcyc = (vcyc + 1) % 400;
    hsync_in = (vcyc % 20) < 4;
    vsync_in = vcyc >= 10 && vcyc < 14;
  end
  task automatic summarize();
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] ra, input int n, input logic [7:0] d0,
                    input logic [7:0] d1);
    logic ok;
    u_host.wr(ra, n, d0, d1, ok);
    chk("write ack", 8'h01, {7'h00, ok});
    repeat (40) @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] ra, input logic [7:0] e);
    logic       ok;
    logic [7:0] d;
    u_host.rd(ra, d, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    chk("read data", e, d);
  endtask
  task automatic t_reset();
    logic [7:0] ra [5] = '{8'h07, 8'h0F, 8'h12, 8'h13, 8'h34};
    logic [7:0] rv [5] = '{8'h00, 8'h3D, 8'h00, 8'h7F, 8'h99};
    chk("brightness", 8'h7F, {1'b0, brightness_level});
    chk("tuning", 8'h3D, cathode_loop_tuning);
    chk("aux0", 8'h99, aux_tuning_config_0);
    chk("aux1", 8'h99, aux_tuning_config_1);
    for (int i = 0; i < 5; i++)
      rd(ra[i], rv[i]);
    rd(8'h50, 8'h00);
    rd(8'h42, 8'h03);
  endtask
  // Host arithmetic that the block leaves to the controller
  task automatic t_host();
    int v;
    v = u_host.lum_nits(8'h05, 8'h80, 8'h01, 8'h02, 8'h80);
    chk("lum", 8'hBF, 8'(v));
    v = u_host.lum_nits(8'h05, 8'h80, 8'h01, 8'h02, 8'h20);
    chk("lum low code", 8'hFF, 8'(v));
    v = u_host.gamma_coef(32'h1F4, 32'h1388, 32'h3D8);
    chk("gamma coef", 8'hC8, 8'(v));
  endtask
  task automatic t_loops();
    wr(8'h13, 1, 8'h64, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h40, 1, 8'(s), 8'h00);
      chk("bright", (s < 2) ? 8'h64 : 8'h7F, {1'b0, brightness_level});
      chk("lum en", {7'h00, s < 2}, {7'h00, lum_reg_enable});
      chk("probe en", {7'h00, s == 0}, {7'h00, probe_enable});
      chk("loop sel", 8'(s), {4'h0, cathode_loop_select});
    end
    wr(8'h40, 1, 8'h00, 8'h00);
  endtask
  task automatic t_peak();
    wr(8'h12, 2, 8'hA5, 8'h30);
    chk("coarse", 8'h14, {3'h0, peak_current_coarse});
    chk("fine", 8'h05, {5'h00, peak_current_fine});
    chk("bright", 8'h30, {1'b0, brightness_level});
    rd(8'h12, 8'hA5);
    wr(8'h13, 1, 8'hFF, 8'h00);
    rd(8'h13, 8'h7F);
  endtask
  task automatic t_profile();
    wr(8'h0F, 1, 8'h11, 8'h00);
    wr(8'h34, 2, 8'h30, 8'h03);
    wr(8'h12, 2, 8'h06, 8'h64);
    chk("tuning", 8'h11, cathode_loop_tuning);
    chk("aux0", 8'h30, aux_tuning_config_0);
    chk("aux1", 8'h03, aux_tuning_config_1);
    chk("fine", 8'h06, {5'h00, peak_current_fine});
    chk("bright", 8'h64, {1'b0, brightness_level});
    wr(8'h0F, 1, 8'h3D, 8'h00);
    wr(8'h34, 2, 8'h99, 8'h99);
    wr(8'h12, 1, 8'h05, 8'h00);
    chk("tuning", 8'h3D, cathode_loop_tuning);
    chk("aux1", 8'h99, aux_tuning_config_1);
    chk("fine", 8'h05, {5'h00, peak_current_fine});
  endtask
  task automatic t_gray();
    for (int g = 0; g < 8; g++)
    begin
      wr(8'h41, 1, 8'(g), 8'h00);
      repeat (400) @(posedge sys_clk);
      @(posedge vsync_in);
      #1;
      chk("gray", 8'(g), {5'h00, gray_point_select});
      chk("probe en", 8'h01, {7'h00, probe_enable});
    end
  endtask
  task automatic t_addr();
    logic ok;
    addr_sel = 1'b1;
    u_host.wr(8'h13, 1, 8'h2A, 8'h00, ok);
    chk("foreign ack", 8'h00, {7'h00, ok});
    chk("bright", 8'h64, {1'b0, brightness_level});
    u_host.dev = 7'h27;
    wr(8'h13, 1, 8'h2A, 8'h00);
    chk("bright", 8'h2A, {1'b0, brightness_level});
    u_host.dev = 7'h26;
    addr_sel = 1'b0;
  endtask
  // Samples late in each line so the cleared line of the next frame counts
  task automatic t_blank();
    int cnt;
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h07, 2, 8'h00, (k == 0) ? 8'h03 : 8'h00);
      repeat (800) @(posedge sys_clk);
      cnt = 0;
      @(posedge vsync_in);
      repeat (20)
      begin
        @(posedge hsync_in);
        repeat (16) @(posedge sys_clk);
        #1;
        cnt += (row_black === 1'b1);
      end
      chk("black lines", (k == 0) ? 8'h06 : 8'h00, 8'(cnt));
    end
  endtask
  initial
  begin
    repeat (5) @(posedge link_clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge link_clk);
    #1;
    t_reset();
    t_host();
    t_loops();
    t_peak();
    t_profile();
    t_gray();
    t_addr();
    t_blank();
    summarize();
  end
endmodule // lgc_top_tb
`default_nettype wire
